// ===== sim/fieldbus_remote_write_regs_bench.sv
`default_nettype none
module fieldbus_remote_write_regs_bench;
   import rwr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in, rstn_in, wr, rd, vec, srev, ack, ivalid, iactive;
   logic [3:0] addr;
   word_t wdata, rdata, d, op_o, tr, tn, pt, pf, pe, fm;
   logic [7:0] pa, es, ts, fs, ie, ic;
   logic [63:0] fc;
   logic tw, rv;
   int failures = 0;
   int samples_checked = 0;
   rwr_if link_if ();
   rwr_master rwr_master_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(link_if.mst),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
   rwr_device rwr_device_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link(link_if.dev),
      .pid_action_param_in(pa), .extended_setting_param_in(es), .torque_source_param_in(ts),
      .freq_sign_select_param_in(fs), .vector_control_in(vec), .start_reverse_in(srev),
      .fault_codes_in(fc), .instr_ack_in(ack), .instr_valid_out(ivalid), .instr_ext_out(ie),
      .instr_code_out(ic), .instr_operand_out(op_o), .pid_target_out(pt), .pid_feedback_out(pf),
      .pid_error_out(pe), .torque_value_ram_param_out(tr), .torque_value_nv_param_out(tn),
      .torque_nv_write_out(tw), .freq_magnitude_out(fm), .reverse_out(rv),
      .instruction_done_out(iactive));
   rwr_properties rwr_properties_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .instruction_execute_request(link_if.instruction_execute_request),
      .instruction_done_flag(link_if.instruction_done_flag),
      .ram_write_request(link_if.ram_write_request),
      .eeprom_write_request(link_if.eeprom_write_request),
      .fault_history_select(link_if.fault_history_select),
      .fault_data_readback(link_if.fault_data_readback),
      .primary_instruction_code(link_if.primary_instruction_code),
      .primary_write_operand(link_if.primary_write_operand));
   // ----------------------------------------
   // Bus helpers
   // ----------------------------------------
   task automatic chk(input string n, input word_t e, input word_t g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wrb(input logic [3:0] a, input word_t v);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask : wrb
   task automatic rdb(input logic [3:0] a);
      @(posedge clk_sys_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rdb
   // No handshake on the link words, so wait past the register stages
   task automatic settle();
      repeat (5) @(posedge clk_sys_in);
   endtask : settle
   task automatic end_sim();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic chain(input bit all_off);
      word_t c[6], o[6];
      int q[$];
      int n;
      n = 0;
      q = {5};
      for (int i = 0; i < 6; i++) begin
         c[i] = (i < 5 && (all_off || i == 2)) ? 16'hFFFF : 16'h0200 + 16'h0101 * i[15:0];
         o[i] = 16'hA000 + i[15:0];
         if (i < 5 && c[i] != 16'hFFFF)
            q.push_back(i);
         wrb(4'h0, word_t'(i) << 4);
         wrb(4'h3, c[i]);
         wrb(4'h2, o[i]);
      end
      wrb(4'h0, 16'h0001);
      for (int t = 0; t < 400 && iactive !== 1'b1; t++) begin
         @(posedge clk_sys_in);
         if (ivalid === 1'b1 && !ack && n < q.size()) begin
            chk("instr", c[q[n]], {ie, ic});
            chk("operand", o[q[n]], op_o);
            n++;
            ack <= 1'b1;
         end else
            ack <= 1'b0;
      end
      ack <= 1'b0;
      chk("count", word_t'(q.size()), word_t'(n));
      chk("done", 16'h0001, word_t'(iactive));
      repeat (4) @(posedge clk_sys_in);
   endtask : chain
   task automatic pid();
      logic [7:0] m[4] = '{8'h32, 8'h33, 8'h3C, 8'h3D};
      foreach (m[k]) begin
         pa <= m[k];
         wrb(4'hA, 16'h2700 + word_t'(k));
         settle();
         chk("target", 16'h2700 + word_t'(k), pt);
      end
      wrb(4'hA, 16'h2710);
      wrb(4'hB, 16'h2711);
      wrb(4'hC, 16'hD8F0);
      settle();
      chk("target", 16'h2710, pt);
      chk("feedback", 16'h0000, pf);
      chk("error", 16'hD8F0, pe);
      wrb(4'hC, 16'hD8EF);
      settle();
      chk("error", 16'hD8F0, pe);
      pa <= 8'h00;
      wrb(4'hA, 16'h0005);
      settle();
      chk("target", 16'h2710, pt);
   endtask : pid
   task automatic torque();
      wrb(4'hD, 16'h1234);
      settle();
      chk("ram copy", 16'h0000, tr);
      wrb(4'h0, 16'h0002);
      repeat (2) @(posedge clk_sys_in);
      chk("nv write", 16'h0001, word_t'(tw));
      @(posedge clk_sys_in);
      chk("nv write", 16'h0000, word_t'(tw));
      settle();
      chk("ram copy", 16'h1234, tr);
      chk("nv copy", 16'h1234, tn);
      es <= 8'h00;
      wrb(4'hD, 16'h5555);
      wrb(4'h0, 16'h0002);
      settle();
      chk("ram copy", 16'h1234, tr);
      es <= 8'h12;
      ts <= 8'h05;
      wrb(4'hD, 16'h0777);
      wrb(4'h0, 16'h0004);
      settle();
      chk("nv copy", 16'h0777, tn);
   endtask : torque
   task automatic fault_and_freq();
      for (int n = 0; n < 8; n++) begin
         wrb(4'h9, {n[7:0], 8'h00});
         settle();
         rdb(4'h4);
         chk("fault", {n[7:0], 8'h11 * (n[7:0] + 8'h01)}, d);
      end
      wrb(4'h8, 16'hFFFF);
      settle();
      chk("magnitude", 16'h0001, fm);
      chk("reverse", 16'h0001, word_t'(rv));
      srev <= 1'b1;
      wrb(4'h8, 16'h8000);
      settle();
      chk("magnitude", 16'h8000, fm);
      chk("reverse", 16'h0000, word_t'(rv));
      fs <= 8'h00;
      wrb(4'h8, 16'hFFFF);
      settle();
      chk("magnitude", 16'hFFFF, fm);
   endtask : fault_and_freq
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      #400000;
      failures++;
      end_sim();
   end
   initial begin
      {rstn_in, wr, rd, ack, srev} = '0;
      {addr, wdata} = '0;
      pa = 8'h32;
      fs = 8'h01;
      {es, ts, vec} = {8'h0E, 8'h03, 1'b1};
      fc = 64'h8877665544332211;
      repeat (16) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      chain(1'b0);
      chain(1'b1);
      pid();
      torque();
      fault_and_freq();
      end_sim();
   end
endmodule : fieldbus_remote_write_regs_bench
`default_nettype wire

// ===== sim/rwr_properties.sv
`default_nettype none
module rwr_properties
   import rwr_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic instruction_execute_request,
   input wire logic instruction_done_flag,
   input wire logic ram_write_request,
   input wire logic eeprom_write_request,
   input wire word_t fault_history_select,
   input wire word_t fault_data_readback,
   input wire word_t primary_instruction_code,
   input wire word_t primary_write_operand
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   wire logic exe = instruction_execute_request;
   wire logic done = instruction_done_flag;
   // ----------------------------------------
   // Sequencing and handshakes
   // ----------------------------------------
   AST_DONE_NEEDS_EXEC: assert property ($rose(done) |-> exe)
      else $error("done rose without execute request");
   AST_DONE_NOT_EARLY: assert property ($rose(exe) |=> !done [*3])
      else $error("done too soon after execute");
   AST_DONE_FALLS: assert property ($fell(exe) |-> ##[0:2] !done)
      else $error("done stuck after execute dropped");
   AST_DONE_HOLD: assert property (done && exe |=> done)
      else $error("done dropped while execute held");
   AST_EXEC_HOLD: assert property (exe && !done |=> exe)
      else $error("execute released before done");
   AST_LOAD_FIRST: assert property ($rose(exe) |-> $stable(primary_instruction_code)
      && $stable(primary_write_operand))
      else $error("primary words changed with execute");
   AST_RAM_PULSE: assert property (ram_write_request |=> !ram_write_request)
      else $error("ram write request longer than one cycle");
   AST_EE_PULSE: assert property (eeprom_write_request |=> !eeprom_write_request)
      else $error("eeprom write request longer than one cycle");
   // Echo is checked only for records 0..7; higher selections also echo and wrap onto record hsel[2:0]
   AST_FAULT_ECHO: assert property (($stable(fault_history_select) && fault_history_select[15:8]
      <= 8'h07) [*3] |-> fault_data_readback[15:8] == fault_history_select[15:8])
      else $error("fault readback echo wrong");
   cover property ($rose(done));
   cover property ($rose(ram_write_request));
   cover property ($rose(eeprom_write_request));
endmodule : rwr_properties
`default_nettype wire

// ===== src/rwr_device.sv
`include "rwr_params.svh"
`default_nettype none
module rwr_device
   import rwr_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   rwr_if.dev link,
   input wire logic [7:0] pid_action_param_in,
   input wire logic [7:0] extended_setting_param_in,
   input wire logic [7:0] torque_source_param_in,
   input wire logic [7:0] freq_sign_select_param_in,
   input wire logic vector_control_in,
   input wire logic start_reverse_in,
   input wire logic [63:0] fault_codes_in,
   input wire logic instr_ack_in,
   output logic instr_valid_out,
   output logic [7:0] instr_ext_out,
   output logic [7:0] instr_code_out,
   output logic [15:0] instr_operand_out,
   output logic [15:0] pid_target_out,
   output logic [15:0] pid_feedback_out,
   output logic [15:0] pid_error_out,
   output logic [15:0] torque_value_ram_param_out,
   output logic [15:0] torque_value_nv_param_out,
   output logic torque_nv_write_out,
   output logic [15:0] freq_magnitude_out,
   output logic reverse_out,
   output logic instruction_done_out
);
   // ---------------------------------------------------------------
   // PID inputs
   // ---------------------------------------------------------------
   word_t pid_t_reg, pid_f_reg, pid_e_reg;
   wire pid_mode = pid_action_param_in == `PID_ACT_A || pid_action_param_in == `PID_ACT_B ||
      pid_action_param_in == `PID_ACT_C || pid_action_param_in == `PID_ACT_D;
   wire t_ok = !link.pid_target_percent[15] &&
      $signed(link.pid_target_percent) <= `PID_MAX;
   wire f_ok = !link.pid_feedback_percent[15] &&
      $signed(link.pid_feedback_percent) <= `PID_MAX;
   wire e_ok = $signed(link.pid_error_percent) <= `PID_MAX &&
      $signed(link.pid_error_percent) >= `PID_MIN;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pid_t_reg <= 16'h0000;
         pid_f_reg <= 16'h0000;
         pid_e_reg <= 16'h0000;
      end else if (pid_mode) begin
         if (t_ok) pid_t_reg <= link.pid_target_percent;
         if (f_ok) pid_f_reg <= link.pid_feedback_percent;
         if (e_ok) pid_e_reg <= link.pid_error_percent;
      end
   end
   assign pid_target_out = pid_t_reg;
   assign pid_feedback_out = pid_f_reg;
   assign pid_error_out = pid_e_reg;

   // ---------------------------------------------------------------
   // Torque command
   // ---------------------------------------------------------------
   word_t trq_ram_reg, trq_nv_reg;
   logic trq_nv_wr_reg;
   wire trq_mode = (extended_setting_param_in == `EXT_SET_A ||
      extended_setting_param_in == `EXT_SET_B) &&
      (torque_source_param_in == `TRQ_SRC_A || torque_source_param_in == `TRQ_SRC_B) &&
      vector_control_in;
   wire trq_wr = trq_mode && (link.ram_write_request || link.eeprom_write_request);
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         trq_ram_reg <= 16'h0000;
         trq_nv_reg <= 16'h0000;
         trq_nv_wr_reg <= 1'b0;
      end else begin
         trq_nv_wr_reg <= trq_wr;
         if (trq_wr) begin
            trq_ram_reg <= link.torque_command_extended;
            trq_nv_reg <= link.torque_command_extended;
         end
      end
   end
   assign torque_value_ram_param_out = trq_ram_reg;
   assign torque_value_nv_param_out = trq_nv_reg;
   assign torque_nv_write_out = trq_nv_wr_reg;

   // ---------------------------------------------------------------
   // Frequency sign
   // ---------------------------------------------------------------
   logic [15:0] fmag_reg;
   logic rev_reg;
   wire sgn = freq_sign_select_param_in == `SIGNED_SEL;
   wire neg = sgn && link.freq_command[15];
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fmag_reg <= 16'h0000;
         rev_reg <= 1'b0;
      end else begin
         fmag_reg <= neg ? 16'(-link.freq_command) : link.freq_command;
         rev_reg <= start_reverse_in ^ neg;
      end
   end
   assign freq_magnitude_out = fmag_reg;
   assign reverse_out = rev_reg;

   // ---------------------------------------------------------------
   // Fault readback
   // ---------------------------------------------------------------
   word_t fault_reg;
   wire [7:0] hsel = link.fault_history_select[15:8];
   wire [7:0] frec = fault_codes_in[{hsel[2:0], 3'b000} +: 8];
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) fault_reg <= 16'h0000;
      else fault_reg <= {hsel, frec};
   end
   assign link.fault_data_readback = fault_reg;

   // ---------------------------------------------------------------
   // Instruction chain
   // ---------------------------------------------------------------
   seq_t st_reg;
   logic [2:0] idx_reg;
   logic done_reg, req_d_reg, valid_reg;
   word_t code_reg, op_reg;
   wire req_rise = link.instruction_execute_request && !req_d_reg;
   wire [2:0] sl = idx_reg - 3'd1;
   wire word_t cur_code = idx_reg == 3'd0 ? link.primary_instruction_code :
      link.extra_instruction_slot[sl];
   wire word_t cur_op = idx_reg == 3'd0 ? link.primary_write_operand :
      link.extra_write_operand[sl];
   wire skip = idx_reg != 3'd0 && cur_code == `SLOT_DISABLE;
   wire last = idx_reg == 3'(`SLOT_COUNT);
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg <= SEQ_IDLE;
         idx_reg <= 3'd0;
         done_reg <= 1'b0;
         req_d_reg <= 1'b0;
         valid_reg <= 1'b0;
         code_reg <= 16'h0000;
         op_reg <= 16'h0000;
      end else begin
         req_d_reg <= link.instruction_execute_request;
         unique case (st_reg)
            SEQ_IDLE: begin
               if (!link.instruction_execute_request) done_reg <= 1'b0;
               if (req_rise) begin
                  idx_reg <= 3'd0;
                  done_reg <= 1'b0;
                  st_reg <= SEQ_RUN;
               end
            end
            SEQ_RUN: begin
               if (valid_reg) begin
                  if (instr_ack_in) begin
                     valid_reg <= 1'b0;
                     if (last) st_reg <= SEQ_DONE;
                     else idx_reg <= idx_reg + 3'd1;
                  end
               end else if (skip) begin
                  if (last) st_reg <= SEQ_DONE;
                  else idx_reg <= idx_reg + 3'd1;
               end else begin
                  code_reg <= cur_code;
                  op_reg <= cur_op;
                  valid_reg <= 1'b1;
               end
            end
            SEQ_DONE: begin
               done_reg <= 1'b1;
               st_reg <= SEQ_IDLE;
            end
            default: st_reg <= SEQ_IDLE;
         endcase
      end
   end
   assign instr_valid_out = valid_reg;
   assign instr_ext_out = code_reg[15:8];
   assign instr_code_out = code_reg[7:0];
   assign instr_operand_out = op_reg;
   assign instruction_done_out = done_reg;
   assign link.instruction_done_flag = done_reg;
endmodule : rwr_device
`default_nettype wire

// ===== src/rwr_if.sv
`default_nettype none
interface rwr_if;
   import rwr_pkg::*;
   word_t fault_history_select;
   word_t pid_target_percent;
   word_t pid_feedback_percent;
   word_t pid_error_percent;
   word_t torque_command_extended;
   word_t primary_instruction_code;
   word_t primary_write_operand;
   word_t extra_instruction_slot [5];
   word_t extra_write_operand [5];
   word_t freq_command;
   logic instruction_execute_request;
   logic ram_write_request;
   logic eeprom_write_request;
   logic instruction_done_flag;
   word_t fault_data_readback;
   modport dev (input fault_history_select, pid_target_percent, pid_feedback_percent,
      pid_error_percent, torque_command_extended, primary_instruction_code,
      primary_write_operand, extra_instruction_slot, extra_write_operand, freq_command,
      instruction_execute_request, ram_write_request, eeprom_write_request,
      output instruction_done_flag, fault_data_readback);
   modport mst (output fault_history_select, pid_target_percent, pid_feedback_percent,
      pid_error_percent, torque_command_extended, primary_instruction_code,
      primary_write_operand, extra_instruction_slot, extra_write_operand, freq_command,
      instruction_execute_request, ram_write_request, eeprom_write_request,
      input instruction_done_flag, fault_data_readback);
endinterface : rwr_if
`default_nettype wire

// ===== src/rwr_master.sv
`include "rwr_params.svh"
`default_nettype none
module rwr_master
   import rwr_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   rwr_if.mst link,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out
);
   // ---------------------------------------------------------------
   // Shadow words, all but w_reg[12] sent whole every cycle
   // ---------------------------------------------------------------
   word_t w_reg [13];
   word_t ops_reg [6];
   word_t rd_reg;
   logic exec_reg, ramw_reg, eew_reg;
   logic [2:0] sel_reg;
   wire [3:0] a = addr_in;
   wire word_t stat = {14'h0000, exec_reg, link.instruction_done_flag};
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < 13; i++) w_reg[i] <= 16'h0000;
         for (int i = 0; i < 6; i++) ops_reg[i] <= 16'h0000;
         rd_reg <= 16'h0000;
         exec_reg <= 1'b0;
         ramw_reg <= 1'b0;
         eew_reg <= 1'b0;
         sel_reg <= 3'd0;
      end else begin
         ramw_reg <= 1'b0;
         eew_reg <= 1'b0;
         if (link.instruction_done_flag) exec_reg <= 1'b0;
         if (wr_in) begin
            unique case (a)
               `REG_CMD: begin
                  exec_reg <= wdata_in[0];
                  ramw_reg <= wdata_in[1];
                  eew_reg <= wdata_in[2];
                  sel_reg <= wdata_in[6:4];
               end
               `REG_OP: ops_reg[sel_reg] <= wdata_in;
               `REG_DATA: w_reg[sel_reg] <= wdata_in;
               default: if (a >= 4'h7) w_reg[4'(a - 4'h2)] <= wdata_in;
            endcase
         end
         if (rd_in) begin
            rd_reg <= a == `REG_STAT ? stat :
               a == `REG_FAULT ? link.fault_data_readback : 16'h0000;
         end
      end
   end
   // Map: w_reg 0..4 extra slots, 5 primary, 6 freq, 7..11 hist/pid/pid/pid/torque
   assign link.extra_instruction_slot[0] = w_reg[0];
   assign link.extra_instruction_slot[1] = w_reg[1];
   assign link.extra_instruction_slot[2] = w_reg[2];
   assign link.extra_instruction_slot[3] = w_reg[3];
   assign link.extra_instruction_slot[4] = w_reg[4];
   assign link.extra_write_operand[0] = ops_reg[0];
   assign link.extra_write_operand[1] = ops_reg[1];
   assign link.extra_write_operand[2] = ops_reg[2];
   assign link.extra_write_operand[3] = ops_reg[3];
   assign link.extra_write_operand[4] = ops_reg[4];
   assign link.primary_write_operand = ops_reg[5];
   assign link.primary_instruction_code = w_reg[5];
   assign link.freq_command = w_reg[6];
   assign link.fault_history_select = w_reg[7];
   assign link.pid_target_percent = w_reg[8];
   assign link.pid_feedback_percent = w_reg[9];
   assign link.pid_error_percent = w_reg[10];
   assign link.torque_command_extended = w_reg[11];
   assign link.instruction_execute_request = exec_reg;
   assign link.ram_write_request = ramw_reg;
   assign link.eeprom_write_request = eew_reg;
   assign rdata_out = rd_reg;
endmodule : rwr_master
`default_nettype wire

// ===== src/rwr_params.svh
`ifndef RWR_PARAMS_SVH
`define RWR_PARAMS_SVH
`define HIST_MAX 8'h07
`define HIST_SHIFT 8
`define PID_MAX 16'sh2710
`define PID_MIN -16'sh2710
`define PID_ACT_A 8'h32
`define PID_ACT_B 8'h33
`define PID_ACT_C 8'h3C
`define PID_ACT_D 8'h3D
`define EXT_SET_A 8'h0E
`define EXT_SET_B 8'h12
`define TRQ_SRC_A 8'h03
`define TRQ_SRC_B 8'h05
`define SLOT_DISABLE 16'hFFFF
`define SLOT_COUNT 5
`define EXEC_CYCLES 4'h3
`define SIGNED_SEL 8'h01
`define REG_CMD 4'h0
`define REG_STAT 4'h1
`define REG_OP 4'h2
`define REG_DATA 4'h3
`define REG_FAULT 4'h4
`define REG_TRQ 4'h5
`define REG_FREQ 4'h6
`endif

// ===== src/rwr_pkg.sv
`default_nettype none
package rwr_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [2:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} seq_t;
endpackage : rwr_pkg
`default_nettype wire
